/* cmpl_channel.sv */
// Channel mode, loop-back and PRBS test control with APB register access
// Operation
// - PRBS on at DS3 or STS-1 sends unframed 2^15-1 pattern.
// - PRBS on at E3 sends unframed 2^23-1 pattern.
// - PRBS on arms the checker on recovered data for the rate pattern.
// - Enable bit turns generator and checker on or off together.
// - Rail bit 0 makes negative rail output carry PRBS errors.
// - PRBS on replaces system transmit data with the pattern.
// - Local/remote bits pick normal, remote, analog or digital loop.
// - Rate family bit 1 forces E3 whatever the select bit.
// - Rate family bit 0 runs DS3 or STS-1 per bit 1.
// - Select 0 is DS3, select 1 is STS-1.
// - Single rail: codec on, data on positive rail, negative is violation while PRBS is off.
`timescale 1ns/1ps
`default_nettype none
module cmpl_channel (
    // Clock and reset
    input  wire logic                             i_clk,
    input  wire logic                             i_resetn,
    // APB slave
    input  wire logic                             i_psel,
    input  wire logic                             i_penable,
    input  wire logic                             i_pwrite,
    input  wire logic [cmpl_pkg::CMPL_ADDR_W-1:0] i_paddr,
    input  wire logic [cmpl_pkg::CMPL_DATA_W-1:0] i_pwdata,
    output logic      [cmpl_pkg::CMPL_DATA_W-1:0] o_prdata,
    output logic                                  o_pready,
    output logic                                  o_pslverr,
    // Mode strap: high selects host control
    input  wire logic                             i_host_mode,
    // Transmit side, one bit per enable pulse
    input  wire logic                             i_tx_bit_en,
    input  wire logic                             i_tx_positive_data_in,
    input  wire logic                             i_tx_negative_data_in,
    output logic                                  o_tx_pos,
    output logic                                  o_tx_neg,
    output logic                                  o_tx_ready,
    // Receive side, one bit per enable pulse
    input  wire logic                             i_rx_bit_en,
    input  wire logic                             i_rx_pos,
    input  wire logic                             i_rx_neg,
    input  wire logic                             i_rx_violation,
    output logic                                  o_rx_positive_data_out,
    output logic                                  o_neg_rail_or_violation_out,
    // Decoded mode outputs
    output logic                                  o_codec_enable,
    output cmpl_pkg::cmpl_rate_t                  o_rate,
    output cmpl_pkg::cmpl_loop_t                  o_loop
);
    import cmpl_pkg::*;

    logic [7:0]             ctrl;
    logic [7:0]             next_ctrl;
    logic [CMPL_DATA_W-1:0] next_prdata;
    logic                   next_pready;
    logic                   next_pslverr;
    logic [1:0]             host_sync;
    logic                   host_mode;
    logic                   prbs_on;
    logic                   setup;
    logic                   acc_phase;
    logic                   is_e3;

    // Host mode strap passes two flops
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            host_sync <= 2'b00;
        end else begin
            host_sync <= {host_sync[0], i_host_mode};
        end
    end
    assign host_mode = host_sync[1];
    assign prbs_on   = ctrl[CMPL_PRBS_BIT] && host_mode;
    assign is_e3     = ctrl[CMPL_RATE_BIT];

    // APB decode: answer registered at setup, a write lands only at the pready edge
    always_comb begin
        setup        = i_psel && !i_penable;
        acc_phase    = i_psel && i_penable && o_pready;
        next_ctrl    = ctrl;
        next_prdata  = o_prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (acc_phase && i_pwrite && (i_paddr == CMPL_CTRL_ADDR)) begin
            next_ctrl = i_pwdata[7:0] & CMPL_CTRL_WMASK;
        end
        if (setup) begin
            next_pready = 1'b1;
            if (i_paddr == CMPL_CTRL_ADDR) begin
                if (!i_pwrite) begin
                    next_prdata = {24'h000000, ctrl};
                end
            end else if (i_paddr == CMPL_STAT_ADDR) begin
                next_prdata = i_pwrite ? o_prdata
                            : {28'h0000000, host_mode, prbs_on, o_loop};
            end else begin
                next_pslverr = 1'b1;
                next_prdata  = 32'h00000000;
            end
        end
    end

    // Register bank, reset to all zero
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl      <= CMPL_CTRL_RESET;
            o_prdata  <= 32'h00000000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            o_prdata  <= next_prdata;
            o_pready  <= next_pready;
            o_pslverr <= next_pslverr;
        end
    end

    // Mode decode
    cmpl_rate_t next_rate;
    cmpl_loop_t next_loop;
    logic       next_codec;
    always_comb begin
        if (is_e3) begin
            next_rate = CMPL_RATE_E3;
        end else if (ctrl[CMPL_SONET_BIT]) begin
            next_rate = CMPL_RATE_STS1;
        end else begin
            next_rate = CMPL_RATE_DS3;
        end
        case ({ctrl[CMPL_LLOOP_BIT], ctrl[CMPL_RLOOP_BIT]})
            2'b00:   next_loop = CMPL_LOOP_NORMAL;
            2'b01:   next_loop = CMPL_LOOP_REMOTE;
            2'b10:   next_loop = CMPL_LOOP_ANALOG;
            default: next_loop = CMPL_LOOP_DIGITAL;
        endcase
        next_codec = !ctrl[CMPL_RAIL_BIT];
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rate         <= CMPL_RATE_DS3;
            o_loop         <= CMPL_LOOP_NORMAL;
            o_codec_enable <= 1'b1;
        end else begin
            o_rate         <= next_rate;
            o_loop         <= next_loop;
            o_codec_enable <= next_codec;
        end
    end

    // System transmit data is buffered; PRBS mode drains and drops it
    logic       fifo_valid;
    logic [1:0] fifo_data;
    logic       fifo_in_ready;
    cmpl_fifo #(
        .WIDTH(CMPL_FIFO_W),
        .DEPTH(CMPL_FIFO_D)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_in_valid  (i_tx_bit_en),
        .i_in_data   ({i_tx_positive_data_in, i_tx_negative_data_in}),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (fifo_valid),
        .o_out_data  (fifo_data),
        .i_out_ready (i_tx_bit_en)
    );

    // Pattern generator
    logic [CMPL_PRBS_W-1:0] gen;
    logic [CMPL_PRBS_W-1:0] next_gen;
    logic                   gen_bit;
    logic                   next_tx_pos;
    logic                   next_tx_neg;
    always_comb begin
        gen_bit = is_e3 ? gen[CMPL_E3_TAP_A] ^ gen[CMPL_E3_TAP_B]
                        : gen[CMPL_T3_TAP_A] ^ gen[CMPL_T3_TAP_B];
        next_gen    = gen;
        next_tx_pos = o_tx_pos;
        next_tx_neg = o_tx_neg;
        if (!prbs_on) begin
            next_gen = CMPL_SEED;
        end else if (i_tx_bit_en) begin
            next_gen = {gen[CMPL_PRBS_W-2:0], gen_bit};
        end
        if (i_tx_bit_en) begin
            if (prbs_on) begin
                next_tx_pos = gen_bit;
                next_tx_neg = 1'b0;
            end else begin
                next_tx_pos = fifo_valid & fifo_data[1];
                next_tx_neg = fifo_valid & fifo_data[0];
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gen        <= CMPL_SEED;
            o_tx_pos   <= 1'b0;
            o_tx_neg   <= 1'b0;
            o_tx_ready <= 1'b0;
        end else begin
            gen        <= next_gen;
            o_tx_pos   <= next_tx_pos;
            o_tx_neg   <= next_tx_neg;
            o_tx_ready <= fifo_in_ready;
        end
    end

    // Pattern checker: self-synchronising, shifts in received bits
    logic [CMPL_PRBS_W-1:0] chk;
    logic [CMPL_PRBS_W-1:0] next_chk;
    logic                   exp_bit;
    logic                   err;
    logic                   next_rx_pos;
    logic                   next_neg_out;
    always_comb begin
        exp_bit  = is_e3 ? chk[CMPL_E3_TAP_A] ^ chk[CMPL_E3_TAP_B]
                         : chk[CMPL_T3_TAP_A] ^ chk[CMPL_T3_TAP_B];
        err      = prbs_on && i_rx_bit_en && (exp_bit != i_rx_pos);
        next_chk = chk;
        if (!prbs_on) begin
            next_chk = CMPL_ZERO23;
        end else if (i_rx_bit_en) begin
            next_chk = {chk[CMPL_PRBS_W-2:0], i_rx_pos};
        end
        next_rx_pos  = o_rx_positive_data_out;
        next_neg_out = o_neg_rail_or_violation_out;
        if (i_rx_bit_en) begin
            next_rx_pos = i_rx_pos;
            if (ctrl[CMPL_RAIL_BIT]) begin
                next_neg_out = i_rx_neg;
            end else if (prbs_on) begin
                next_neg_out = err;
            end else begin
                next_neg_out = i_rx_violation;
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            chk                         <= CMPL_ZERO23;
            o_rx_positive_data_out      <= 1'b0;
            o_neg_rail_or_violation_out <= 1'b0;
        end else begin
            chk                         <= next_chk;
            o_rx_positive_data_out      <= next_rx_pos;
            o_neg_rail_or_violation_out <= next_neg_out;
        end
    end

    // Checks
    property p_rate_e3;
        @(posedge i_clk) disable iff (!i_resetn)
        ctrl[CMPL_RATE_BIT] |=> (o_rate == CMPL_RATE_E3);
    endproperty
    a_rate_e3: assert property (p_rate_e3) else $error("E3 not selected");
    property p_rate_t3;
        @(posedge i_clk) disable iff (!i_resetn)
        !ctrl[CMPL_RATE_BIT] |=> (o_rate == ($past(ctrl[CMPL_SONET_BIT]) ? CMPL_RATE_STS1
                                                                        : CMPL_RATE_DS3));
    endproperty
    a_rate_t3: assert property (p_rate_t3) else $error("DS3/STS-1 wrong");
    property p_loop;
        @(posedge i_clk) disable iff (!i_resetn)
        ({ctrl[CMPL_RLOOP_BIT], ctrl[CMPL_LLOOP_BIT]} == 2'b01) |=> (o_loop == CMPL_LOOP_ANALOG);
    endproperty
    a_loop: assert property (p_loop) else $error("Loop mode wrong");
    property p_wr_en;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_psel && i_penable && o_pready && i_pwrite && (i_paddr == CMPL_CTRL_ADDR))
            |=> (ctrl[CMPL_PRBS_BIT] == $past(i_pwdata[CMPL_PRBS_BIT]));
    endproperty
    a_wr_en: assert property (p_wr_en) else $error("Enable bit not written");
    property p_tx_prbs;
        @(posedge i_clk) disable iff (!i_resetn)
        (prbs_on && i_tx_bit_en) |=> (o_tx_pos == $past(gen_bit)) && !o_tx_neg;
    endproperty
    a_tx_prbs: assert property (p_tx_prbs) else $error("Pattern not sent");
    property p_off;
        @(posedge i_clk) disable iff (!i_resetn)
        !prbs_on |=> (chk == CMPL_ZERO23) && (gen == CMPL_SEED);
    endproperty
    a_off: assert property (p_off) else $error("Test logic not off");
    property p_strap;
        @(posedge i_clk) disable iff (!i_resetn)
        !host_mode |-> !prbs_on;
    endproperty
    a_strap: assert property (p_strap) else $error("PRBS in strap mode");
    property p_err;
        @(posedge i_clk) disable iff (!i_resetn)
        (err && !ctrl[CMPL_RAIL_BIT]) |=> o_neg_rail_or_violation_out;
    endproperty
    a_err: assert property (p_err) else $error("Error not flagged");
    property p_err_pulse;
        @(posedge i_clk) disable iff (!i_resetn)
        (prbs_on && !ctrl[CMPL_RAIL_BIT] && i_rx_bit_en && !err) |=> !o_neg_rail_or_violation_out;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("Spurious error");
    property p_codec;
        @(posedge i_clk) disable iff (!i_resetn)
        !ctrl[CMPL_RAIL_BIT] ##1 !ctrl[CMPL_RAIL_BIT] |-> o_codec_enable;
    endproperty
    a_codec: assert property (p_codec) else $error("Codec off");
endmodule
`default_nettype wire

/* cmpl_far_model.sv */
// Far-side system logic model: loops line data back and tallies error pulses
`timescale 1ns/1ps
`default_nettype none
module cmpl_far_model (
    // Clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_resetn,
    // Line data and error indicator from the channel, and commanded corruption
    input  wire logic   i_bit_en,
    input  wire logic   i_tx_pos,
    input  wire logic   i_flip,
    input  wire logic   i_err,
    // Recovered stream and error tally
    output logic        o_rx_en,
    output logic        o_rx_pos,
    output logic [15:0] o_err_count
);
    logic        next_rx_en;
    logic        next_rx_pos;
    logic [15:0] next_err_count;
    logic        rx_en_d;
    logic        next_rx_en_d;
    // Between bits the data line toggles so stale values never pass
    always_comb begin
        next_rx_en     = i_bit_en;
        next_rx_pos    = i_bit_en ? (i_tx_pos ^ i_flip) : ~o_rx_pos;
        next_rx_en_d   = o_rx_en;
        // The indicator stands a whole bit: count it once, the cycle after the bit
        next_err_count = o_err_count + {15'h0000, i_err & rx_en_d};
    end
    // State registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_en     <= 1'b0;
            o_rx_pos    <= 1'b0;
            o_err_count <= 16'h0000;
            rx_en_d     <= 1'b0;
        end else begin
            o_rx_en     <= next_rx_en;
            rx_en_d     <= next_rx_en_d;
            o_rx_pos    <= next_rx_pos;
            o_err_count <= next_err_count;
        end
    end
endmodule
`default_nettype wire

/* cmpl_fifo.sv */
// Synchronous valid/ready FIFO on flip-flop storage
`timescale 1ns/1ps
`default_nettype none
module cmpl_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wptr;
    logic [AW-1:0]    next_rptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    // Pointer and count updates
    always_comb begin
        push       = i_in_valid && (count != DEPTH[AW:0]);
        pop        = i_out_ready && (count != '0);
        next_wptr  = push ? wptr + 1'b1 : wptr;
        next_rptr  = pop ? rptr + 1'b1 : rptr;
        next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // Storage entries
    for (genvar g = 0; g < DEPTH; g++) begin : g_ent
        always_comb begin
            next_mem[g] = (push && wptr == AW'(g)) ? i_in_data : mem[g];
        end
        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                mem[g] <= '0;
            end else begin
                mem[g] <= next_mem[g];
            end
        end
    end

    // Pointer registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            count <= next_count;
        end
    end

    assign o_in_ready  = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rptr];
endmodule
`default_nettype wire

/* cmpl_pkg.sv */
// Package: register map, field positions, modes and constants for the channel mode block
package cmpl_pkg;
    localparam int          CMPL_DATA_W      = 32;
    localparam int          CMPL_ADDR_W      = 12;
    // Register byte addresses
    localparam logic [11:0] CMPL_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] CMPL_STAT_ADDR   = 12'h004;
    // Control register field positions
    localparam int          CMPL_RAIL_BIT    = 0;
    localparam int          CMPL_SONET_BIT   = 1;
    localparam int          CMPL_RATE_BIT    = 2;
    localparam int          CMPL_LLOOP_BIT   = 3;
    localparam int          CMPL_RLOOP_BIT   = 4;
    localparam int          CMPL_PRBS_BIT    = 5;
    localparam logic [7:0]  CMPL_CTRL_RESET  = 8'h00;
    localparam logic [7:0]  CMPL_CTRL_WMASK  = 8'h3F;
    // PRBS generators: 2^15-1 uses taps 15,14; 2^23-1 uses taps 23,18
    localparam int          CMPL_PRBS_W      = 23;
    localparam int          CMPL_T3_TAP_A    = 14;
    localparam int          CMPL_T3_TAP_B    = 13;
    localparam int          CMPL_E3_TAP_A    = 22;
    localparam int          CMPL_E3_TAP_B    = 17;
    localparam logic [22:0] CMPL_SEED        = 23'h7FFFFF;
    localparam logic [22:0] CMPL_ZERO23      = 23'h000000;
    localparam int          CMPL_FIFO_W      = 2;
    localparam int          CMPL_FIFO_D      = 8;
    typedef enum logic [1:0] {
        CMPL_RATE_DS3,
        CMPL_RATE_STS1,
        CMPL_RATE_E3
    } cmpl_rate_t;
    typedef enum logic [1:0] {
        CMPL_LOOP_NORMAL,
        CMPL_LOOP_REMOTE,
        CMPL_LOOP_ANALOG,
        CMPL_LOOP_DIGITAL
    } cmpl_loop_t;
endpackage

/* testbench.sv */
// Self-checking testbench for the channel mode and pattern test block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cmpl_pkg::*;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, host = 1;
    logic txen = 0, txp = 0, txn = 0, rxneg = 0, rxvio = 0, flip = 0, err, lastp, lastn;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdat = 32'h0, rdat, prdata, seed = 32'h00000062;
    logic pready, pslverr, txpos, txneg, txrdy, rxen, rxpos, rxout, negout, codec;
    logic [15:0] ecnt;
    logic [63:0] hist;
    cmpl_rate_t rate;
    cmpl_loop_t loop;
    int num_errors = 0, cmp_count = 0;
    always #5 clk = ~clk;
    // Device and far side
    cmpl_channel dut_u (.i_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_host_mode(host), .i_tx_bit_en(txen),
        .i_tx_positive_data_in(txp), .i_tx_negative_data_in(txn), .o_tx_pos(txpos),
        .o_tx_neg(txneg), .o_tx_ready(txrdy), .i_rx_bit_en(rxen), .i_rx_pos(rxpos),
        .i_rx_neg(rxneg), .i_rx_violation(rxvio), .o_rx_positive_data_out(rxout),
        .o_neg_rail_or_violation_out(negout), .o_codec_enable(codec), .o_rate(rate),
        .o_loop(loop));
    cmpl_far_model far_u (.i_clk(clk), .i_resetn(rstn), .i_bit_en(txen), .i_tx_pos(txpos),
        .i_flip(flip), .i_err(negout), .o_rx_en(rxen), .o_rx_pos(rxpos), .o_err_count(ecnt));
    // Xorshift source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected rate from control bits
    function automatic cmpl_rate_t rate_of(logic [7:0] c);
        return c[2] ? CMPL_RATE_E3 : (c[1] ? CMPL_RATE_STS1 : CMPL_RATE_DS3);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One APB transfer, waiting for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; addr <= a; wdat <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rdat = prdata;
        err = pslverr;
        psel <= 0; pen <= 0;
        if (n == 20) begin
            num_errors++;
            $display("BAD %0t no pready", $time);
        end
    endtask
    // One bit period on transmit; output and loop are settled on return
    task automatic bit_go(input logic p, input logic n);
        lastp = txp;
        lastn = txn;
        @(posedge clk);
        txen <= 1; txp <= p; txn <= n;
        @(posedge clk);
        txen <= 0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // Random system data; count lines not showing the previous pair
    task automatic tx_follow(input int nb, output int bad);
        logic [31:0] r;
        bad = 0;
        for (int i = 0; i < nb; i++) begin
            r = xs();
            bit_go(r[0], r[1]);
            if (i > 0 && {txpos, txneg} !== {lastp, lastn}) bad++;
        end
    endtask
    // Random system data; count pattern recurrence breaks and stray negative rail
    task automatic prbs_run(input int a, input int b, input int nb, output int bad);
        logic [31:0] r;
        int ones;
        bad = 0;
        ones = 0;
        for (int i = 0; i < nb; i++) begin
            r = xs();
            bit_go(r[0], r[1]);
            hist = {hist[62:0], txpos};
            ones += txpos;
            if (txneg !== 1'b0) bad++;
            if (i > 1 && rxout !== hist[1]) bad++;
            if (i > b + 1 && hist[0] !== (hist[a] ^ hist[b])) bad++;
        end
        if (ones == 0) bad++;
    endtask
    initial begin
        #200us;
        num_errors++;
        $display("BAD %0t watchdog", $time);
        finish_test();
    end
    initial begin
        int bad, e0;
        logic [31:0] r, c;
        repeat (8) @(posedge clk);
        rstn <= 1;
        repeat (3) @(posedge clk);
        #1;
        chk(codec, 1);
        chk(txrdy, 1);
        chk({rate, loop}, {CMPL_RATE_DS3, CMPL_LOOP_NORMAL});
        apb(0, CMPL_CTRL_ADDR, 0);
        chk(rdat, 0);
        $display("reset test done");
        // Every loop code with random remaining bits, unused bits random too
        for (int i = 0; i < 8; i++) begin
            r = xs();
            c = (r & 32'hFFFFFFE7) | (i[1] << 3) | (i[0] << 4);
            apb(1, CMPL_CTRL_ADDR, c);
            apb(0, CMPL_CTRL_ADDR, 0);
            chk(rdat, c & 32'h3F);
            repeat (2) @(posedge clk);
            #1;
            chk(loop, i[1:0]);
            chk(rate, rate_of(c[7:0]));
            chk(codec, !c[0]);
        end
        apb(0, CMPL_STAT_ADDR, 0);
        chk(rdat[3:0], {host, c[5], c[3], c[4]});
        apb(1, 12'h008, 32'hFF);
        chk(err, 1);
        apb(1, CMPL_STAT_ADDR, 32'hFF);
        apb(0, CMPL_CTRL_ADDR, 0);
        chk(rdat, c & 32'h3F);
        $display("mode test done");
        // Negative rail output under each rail format, pattern test off
        for (int j = 0; j < 4; j++) begin
            apb(1, CMPL_CTRL_ADDR, j[1]);
            rxneg <= j[0];
            rxvio <= ~j[0];
            bit_go(0, 0);
            chk(negout, j[1] ? j[0] : !j[0]);
        end
        tx_follow(12, bad);
        chk(bad, 0);
        $display("rail test done");
        rxneg <= 0;
        rxvio <= 0;
        apb(1, CMPL_CTRL_ADDR, 32'h20);
        prbs_run(14, 15, 60, bad);
        chk(bad, 0);
        e0 = ecnt;
        prbs_run(14, 15, 30, bad);
        chk(ecnt - e0, 0);
        @(posedge clk);
        flip <= 1;
        bit_go(0, 1);
        flip <= 0;
        prbs_run(14, 15, 30, bad);
        chk((ecnt - e0) >= 1 && (ecnt - e0) <= 3, 1);
        apb(1, CMPL_CTRL_ADDR, 32'h26);
        prbs_run(18, 23, 80, bad);
        chk(bad, 0);
        apb(1, CMPL_CTRL_ADDR, 32'h22);
        prbs_run(14, 15, 60, bad);
        chk(bad, 0);
        $display("pattern test done");
        apb(1, CMPL_CTRL_ADDR, 32'h01);
        tx_follow(12, bad);
        chk(bad, 0);
        host <= 0;
        apb(1, CMPL_CTRL_ADDR, 32'h21);
        tx_follow(12, bad);
        chk(bad, 0);
        $display("off and strap test done");
        finish_test();
    end
endmodule
`default_nettype wire
